// ===== asw_pkg.sv
// Purpose: shared constants and carrier types for the scan/watchdog bank
// Assumes: 8-bit registers, one per aligned 32-bit APB word
// Notes:   byte address of a register is four times its index
`default_nettype none
package asw_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LOW_LIMIT_HIGH = 6'h08;
    localparam logic [5:0] IDX_LOW_LIMIT_LOW  = 6'h09;
    localparam logic [5:0] IDX_SEQ_UPPER      = 6'h0a;
    localparam logic [5:0] IDX_SEQ_16_23      = 6'h0b;
    localparam logic [5:0] IDX_SEQ_8_15       = 6'h0c;
    localparam logic [5:0] IDX_SEQ_0_7        = 6'h0d;
    localparam logic [5:0] IDX_HYST_UPPER     = 6'h0e;
    localparam logic [5:0] IDX_HYST_16_23     = 6'h0f;
    localparam logic [5:0] IDX_HYST_8_15      = 6'h10;
    localparam logic [5:0] IDX_HYST_0_7       = 6'h11;
    localparam int         NUM_REGS           = 10;
    localparam logic [7:0] RESET_VALUE        = 8'h00;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int         BIT_DMA_SKIP       = 7;
    localparam int         BIT_PICK_TEMP      = 5;
    localparam int         BIT_PICK_REF       = 4;
    localparam int         BIT_TEMP_REF_ON    = 5;
    localparam int         BIT_INT_REF_ON     = 4;
    localparam logic [7:0] MASK_FULL          = 8'hff;
    localparam logic [7:0] MASK_NONE          = 8'h00;
    localparam logic [7:0] MASK_HI_12BIT      = 8'h0f;
    localparam logic [7:0] MASK_HI_10BIT      = 8'h03;
    localparam logic [7:0] MASK_LO_6BIT       = 8'h3f;
    localparam logic [7:0] MASK_SEQ_UPPER     = 8'hbf;
    localparam logic [7:0] MASK_HYST_UPPER    = 8'h3f;
    localparam logic [7:0] MASK_VALUE_LINE    = 8'h20;
    localparam logic [7:0] MASK_REDUCED       = 8'h0e;
    // ------------------------------------------------------------
    // resolution codes and pseudo-channel numbers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASW_RES_12 = 2'h0,
        ASW_RES_10 = 2'h1,
        ASW_RES_8  = 2'h2,
        ASW_RES_6  = 2'h3
    } asw_res_t;
    localparam logic [4:0] CHAN_INT_REF       = 5'h1c;
    localparam logic [4:0] CHAN_TEMP          = 5'h1d;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        single_result_dma_skip;
        logic        sequence_pick_temp_sensor;
        logic        sequence_pick_internal_ref;
        logic [27:0] sequence_channel_pick;
    } asw_scan_cfg_t;
    typedef struct packed {
        logic        temp_sensor_reference_on;
        logic        internal_reference_on;
        logic [27:0] hysteresis_disable;
    } asw_analog_cfg_t;
endpackage
`default_nettype wire

// ===== asw_regs.sv
// Purpose: upper register bank of the converter, window monitor flag and
//          scan-complete detection
// Assumes: zero-wait APB slave, all inputs on pclk
// Notes:   reserved bits are never stored and read as zero
//
// What this block does
// - offset 0x08 bits 3:0 hold limit MSBs
// - offset 0x09 holds limit low byte
// - reserved bits always read as zero
// - limits right aligned for 12/10-bit resolution
// - 8/6-bit limits live in low byte
// - 0x0A bit 7 skips DMA for result
// - selection bit one puts channel in scan
// - channels 0-23 at 0x0D, 0x0C, 0x0B
// - channels 24-27, reference, sensor at 0x0A
// - reduced variant keeps only channel 24 bit
// - 0x0E bit 5 enables sensor reference
// - 0x0E bit 4 enables internal reference
// - hysteresis bit one disables Schmitt trigger
// - hysteresis channels 0-23 at 0x11, 0x10, 0x0F
// - hysteresis 24-27 at 0x0E bits 3:0
// - every register resets to zero
// - flag when result outside limit window
// - scan done only after last picked channel
// - converter on bit wakes from power-down
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module asw_regs
    import asw_pkg::*;
#(
    parameter bit REDUCED_CHANNELS = 1'b0,
    parameter bit VALUE_LINE       = 1'b0
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire asw_res_t      resolution,
    input  wire logic          converter_on,
    input  wire logic          conv_done,
    input  wire logic [4:0]    conv_channel,
    input  wire logic [11:0]   conv_data,
    input  wire logic [11:0]   window_high_limit,
    input  wire logic          window_flag_clear,
    output var  logic [11:0]   window_low_limit,
    output var  asw_scan_cfg_t scan_cfg,
    output var  asw_analog_cfg_t analog_cfg,
    output var  logic          window_monitor_flag,
    output var  logic          sequence_done,
    output var  logic          converter_powered
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [7:0]  bank [NUM_REGS];
    logic [5:0]  word_index;
    logic [3:0]  slot;
    logic        mapped;
    logic        write_now;
    logic        setup_now;
    logic [7:0]  slot_mask;
    logic [7:0]  read_byte;
    logic [7:0]  upper_variant;

    assign word_index = paddr[7:2];
    assign slot       = 4'(word_index - IDX_LOW_LIMIT_HIGH);
    assign mapped     = (paddr[1:0] == 2'h0)
                     && (word_index >= IDX_LOW_LIMIT_HIGH)
                     && (word_index <= IDX_HYST_0_7);
    assign setup_now  = psel && !penable;
    assign write_now  = psel && penable && pwrite && mapped;

    // variant reserved bits drop out of both upper registers
    assign upper_variant = ~((VALUE_LINE ? MASK_VALUE_LINE : MASK_NONE)
                           | (REDUCED_CHANNELS ? MASK_REDUCED : MASK_NONE));

    // ------------------------------------------------------------
    // writable-bit masks per register and resolution
    // ------------------------------------------------------------
    function automatic logic [7:0] bit_mask(input logic [5:0] idx,
                                            input asw_res_t   res);
        logic [7:0] m;
        m = MASK_FULL;
        case (idx)
            IDX_LOW_LIMIT_HIGH:
                case (res)
                    ASW_RES_12: m = MASK_HI_12BIT;
                    ASW_RES_10: m = MASK_HI_10BIT;
                    default:    m = MASK_NONE;
                endcase
            IDX_LOW_LIMIT_LOW:
                m = (res == ASW_RES_6) ? MASK_LO_6BIT : MASK_FULL;
            IDX_SEQ_UPPER:  m = MASK_SEQ_UPPER & upper_variant;
            IDX_HYST_UPPER: m = MASK_HYST_UPPER & upper_variant;
            default:        m = MASK_FULL;
        endcase
        return m;
    endfunction

    assign slot_mask = bit_mask(word_index, resolution);

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    // masking on write and again on read keeps reserved bits at zero
    // even after the resolution is changed under stored limits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                bank[i] <= RESET_VALUE;
        end
        else if (write_now)
        begin
            bank[slot] <= pwdata[7:0] & slot_mask;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    // data is captured in the setup cycle so prdata comes from a flop
    // and the slave still answers without wait states
    assign read_byte = mapped ? (bank[slot] & slot_mask) : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_now)
            prdata <= {24'h00_0000, read_byte};
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    function automatic logic [7:0] held(input logic [5:0] idx);
        return bank[4'(idx - IDX_LOW_LIMIT_HIGH)] & bit_mask(idx, resolution);
    endfunction

    logic [7:0] seq_upper;
    logic [7:0] hyst_upper;
    logic [7:0] limit_high_byte;

    // a process, not assigns: held() reads bank and resolution behind
    // its constant argument, which an assign would never wake up on
    always_comb
    begin
        seq_upper       = held(IDX_SEQ_UPPER);
        hyst_upper      = held(IDX_HYST_UPPER);
        limit_high_byte = held(IDX_LOW_LIMIT_HIGH);
        // right aligned: unused high bits are already masked to zero
        window_low_limit = {limit_high_byte[3:0],
                            held(IDX_LOW_LIMIT_LOW)};
        scan_cfg.single_result_dma_skip     = seq_upper[BIT_DMA_SKIP];
        scan_cfg.sequence_pick_temp_sensor  = seq_upper[BIT_PICK_TEMP];
        scan_cfg.sequence_pick_internal_ref = seq_upper[BIT_PICK_REF];
        scan_cfg.sequence_channel_pick = {seq_upper[3:0],
                                          held(IDX_SEQ_16_23),
                                          held(IDX_SEQ_8_15),
                                          held(IDX_SEQ_0_7)};
        analog_cfg.temp_sensor_reference_on =
            hyst_upper[BIT_TEMP_REF_ON];
        analog_cfg.internal_reference_on =
            hyst_upper[BIT_INT_REF_ON];
        analog_cfg.hysteresis_disable = {hyst_upper[3:0],
                                         held(IDX_HYST_16_23),
                                         held(IDX_HYST_8_15),
                                         held(IDX_HYST_0_7)};
    end

    // ------------------------------------------------------------
    // window monitor flag
    // ------------------------------------------------------------
    logic window_hit;
    assign window_hit = conv_done && ((conv_data > window_high_limit)
                                   || (conv_data < window_low_limit));

    // a hit in the clearing cycle wins; power-down clears outright
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            window_monitor_flag <= 1'b0;
        else if (!converter_on)
            window_monitor_flag <= 1'b0;
        else if (window_hit)
            window_monitor_flag <= 1'b1;
        else if (window_flag_clear)
            window_monitor_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // end of scan detection
    // ------------------------------------------------------------
    // scan runs upward; reference and sensor sit above channel 27.
    // the detector counts those two picks as channels 28 and 29, and
    // reports a finished scan only while the converter is on
    logic [29:0] all_picks;
    logic [4:0]  last_pick;
    assign all_picks = {scan_cfg.sequence_pick_temp_sensor,
                        scan_cfg.sequence_pick_internal_ref,
                        scan_cfg.sequence_channel_pick};

    always_comb
    begin
        last_pick = 5'h00;
        for (int c = 0; c < 30; c++)
            if (all_picks[c])
                last_pick = 5'(c);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sequence_done <= 1'b0;
        else
            sequence_done <= converter_on && conv_done && (|all_picks)
                          && (conv_channel == last_pick);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            converter_powered <= 1'b0;
        else
            converter_powered <= converter_on;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_high_limit_store;
        psel && penable && pwrite && (paddr == {IDX_LOW_LIMIT_HIGH, 2'h0})
        && (resolution == ASW_RES_12) ##1 resolution == ASW_RES_12
        |-> window_low_limit[11:8] == $past(pwdata[3:0]);
    endproperty
    a_high_limit_store: assert property (p_high_limit_store)
        else $error("limit high nibble not stored");

    property p_low_limit_store;
        psel && penable && pwrite && (paddr == {IDX_LOW_LIMIT_LOW, 2'h0})
        && (resolution != ASW_RES_6) ##1 resolution != ASW_RES_6
        |-> window_low_limit[7:0] == $past(pwdata[7:0]);
    endproperty
    a_low_limit_store: assert property (p_low_limit_store)
        else $error("limit low byte not stored");

    property p_reserved_zero;
        psel && !penable && (paddr == {IDX_SEQ_UPPER, 2'h0})
        |=> prdata[31:8] == 24'h00_0000 && prdata[6] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_res10_align;
        resolution == ASW_RES_10 |-> window_low_limit[11:10] == 2'h0;
    endproperty
    a_res10_align: assert property (p_res10_align)
        else $error("10-bit limit not right aligned");

    property p_res6_align;
        resolution == ASW_RES_6 |-> window_low_limit[11:6] == 6'h00;
    endproperty
    a_res6_align: assert property (p_res6_align)
        else $error("6-bit limit not confined to bits 5:0");

    property p_dma_skip;
        psel && penable && pwrite && (paddr == {IDX_SEQ_UPPER, 2'h0})
        |=> scan_cfg.single_result_dma_skip == $past(pwdata[7]);
    endproperty
    a_dma_skip: assert property (p_dma_skip)
        else $error("dma skip bit wrong after write");

    property p_seq_low_map;
        psel && penable && pwrite && (paddr == {IDX_SEQ_0_7, 2'h0})
        |=> scan_cfg.sequence_channel_pick[7:0] == $past(pwdata[7:0]);
    endproperty
    a_seq_low_map: assert property (p_seq_low_map)
        else $error("channel 0-7 picks misplaced");

    property p_hyst_map;
        psel && penable && pwrite && (paddr == {IDX_HYST_8_15, 2'h0})
        |=> analog_cfg.hysteresis_disable[15:8] == $past(pwdata[7:0]);
    endproperty
    a_hyst_map: assert property (p_hyst_map)
        else $error("hysteresis 8-15 misplaced");

    property p_refs_on;
        psel && penable && pwrite && (paddr == {IDX_HYST_UPPER, 2'h0})
        && !VALUE_LINE
        |=> analog_cfg.temp_sensor_reference_on == $past(pwdata[5])
            && analog_cfg.internal_reference_on == $past(pwdata[4]);
    endproperty
    a_refs_on: assert property (p_refs_on)
        else $error("reference enables wrong");

    property p_reduced;
        REDUCED_CHANNELS |-> scan_cfg.sequence_channel_pick[27:25] == 3'h0
                          && analog_cfg.hysteresis_disable[27:25] == 3'h0;
    endproperty
    a_reduced: assert property (p_reduced)
        else $error("reduced variant keeps channels 25-27");

    property p_reset_zero;
        $rose(presetn) |-> window_low_limit == 12'h000
                        && scan_cfg == '0 && analog_cfg == '0;
    endproperty
    a_reset_zero: assert property (@(posedge pclk) p_reset_zero)
        else $error("registers not zero after reset");

    property p_window_flag;
        converter_on && window_hit ##1 converter_on |-> window_monitor_flag;
    endproperty
    a_window_flag: assert property (p_window_flag)
        else $error("window hit did not raise flag");

    property p_scan_done;
        sequence_done |-> $past(conv_done) && $past(conv_channel == last_pick);
    endproperty
    a_scan_done: assert property (p_scan_done)
        else $error("scan done without last channel");

    property p_power_down;
        !converter_on |=> !window_monitor_flag && !converter_powered;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down did not clear state");

    property p_seq_mid_map;
        psel && penable && pwrite && (paddr == {IDX_SEQ_8_15, 2'h0})
        |=> scan_cfg.sequence_channel_pick[15:8] == $past(pwdata[7:0]);
    endproperty
    a_seq_mid_map: assert property (p_seq_mid_map)
        else $error("channel 8-15 picks misplaced");

    property p_hyst_reserved;
        psel && !penable && (paddr == {IDX_HYST_UPPER, 2'h0})
        |=> prdata[7:6] == 2'h0;
    endproperty
    a_hyst_reserved: assert property (p_hyst_reserved)
        else $error("hysteresis reserved bits read nonzero");

    property p_flag_hold;
        window_monitor_flag && converter_on && !window_flag_clear
        |=> window_monitor_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("window flag dropped without clear");

    property p_flag_clear;
        converter_on && window_flag_clear && !window_hit
        |=> !window_monitor_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("window flag survived a clear");

    c_limit_write: cover property (write_now && slot == 4'h0);
    c_window_hit:  cover property (window_hit ##1 window_monitor_flag);
    c_scan_done:   cover property (sequence_done);
    c_unmapped:    cover property (pslverr);
    c_flag_clear:  cover property (window_flag_clear && window_monitor_flag);

endmodule // asw_regs
`default_nettype wire

// ===== asw_regs_tb_top.sv
// Purpose: self-checking bench for the scan and window-limit bank
// Assumes: default parameters, full channel set, zero-wait slave
// Notes:   model keeps bytes masked at write and again at read
`timescale 1ns/1ps
`default_nettype none
module asw_regs_tb_top
    import asw_pkg::*;
;
    logic            pclk = 1'h0;
    logic            presetn = 1'h0;
    logic            psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    logic            pready, pslverr, err;
    asw_res_t        resolution = ASW_RES_12;
    logic            converter_on = 1'h0, conv_done = 1'h0;
    logic [4:0]      conv_channel = 5'h00;
    logic [11:0]     conv_data = 12'h000, window_high_limit = 12'h800;
    logic            window_flag_clear = 1'h0;
    logic [11:0]     window_low_limit;
    asw_scan_cfg_t   scan_cfg;
    asw_analog_cfg_t analog_cfg;
    logic            window_monitor_flag, sequence_done, converter_powered;
    logic [7:0]      mdl [8:17];
    logic [31:0]     seed = 32'h2a232ab7;
    logic            mflag = 1'h0;
    int              n_mismatch = 0;
    int              comparisons = 0;

    asw_regs asw_regs_inst (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .resolution          (resolution),
        .converter_on        (converter_on),
        .conv_done           (conv_done),
        .conv_channel        (conv_channel),
        .conv_data           (conv_data),
        .window_high_limit   (window_high_limit),
        .window_flag_clear   (window_flag_clear),
        .window_low_limit    (window_low_limit),
        .scan_cfg            (scan_cfg),
        .analog_cfg          (analog_cfg),
        .window_monitor_flag (window_monitor_flag),
        .sequence_done       (sequence_done),
        .converter_powered   (converter_powered)
    );

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // model and bus helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] msk(int i);
        case (i)
            8:       return (resolution == ASW_RES_12) ? 8'h0f :
                            (resolution == ASW_RES_10) ? 8'h03 : 8'h00;
            9:       return (resolution == ASW_RES_6) ? 8'h3f : 8'hff;
            10:      return 8'hbf;
            14:      return 8'h3f;
            default: return 8'hff;
        endcase
    endfunction

    function automatic logic [31:0] lowlim();
        return {16'h0, mdl[8] & msk(8), mdl[9] & msk(9)};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // request held until the edge that sees pready; psel stays up
    // so that a following call makes a back-to-back transfer
    task automatic apb(input logic wr, input int idx, input logic [7:0] d);
        int k;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= 8'(idx * 4);
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'h1)
                break;
        end
        if (k == 16)
        begin
            n_mismatch++;
            finish_test();
        end
        rd  = prdata;
        err = pslverr;
    endtask

    task automatic idle();
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        #1;
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        apb(1'h1, idx, d);
        mdl[idx] = d & msk(idx);
        chk(32'(err), 32'h0);
    endtask

    task automatic rdchk(input int idx);
        apb(1'h0, idx, 8'h00);
        chk(rd, {24'h0, mdl[idx] & msk(idx)});
        chk(32'(err), 32'h0);
    endtask

    task automatic outchk();
        chk(32'(window_low_limit), lowlim());
        chk(32'(scan_cfg), {1'h0, mdl[10][7], mdl[10][5], mdl[10][4],
            mdl[10][3:0], mdl[11], mdl[12], mdl[13]});
        chk(32'(analog_cfg), {2'h0, mdl[14][5], mdl[14][4], mdl[14][3:0],
            mdl[15], mdl[16], mdl[17]});
    endtask

    // power-down clears the flag; only an enabled conversion counts
    task automatic conv(input logic [4:0] ch, input logic [11:0] d);
        logic [29:0] picks;
        int          last;
        logic        on;
        picks = {mdl[10][5:0], mdl[11], mdl[12], mdl[13]};
        last  = -1;
        for (int c = 0; c < 30; c++)
            if (picks[c])
                last = c;
        conv_channel <= ch;
        conv_data    <= d;
        conv_done    <= 1'h1;
        @(posedge pclk);
        // enable as the design samples it at this edge
        on = converter_on;
        conv_done <= 1'h0;
        #1;
        if (on && (32'(d) > 32'(window_high_limit) || 32'(d) < lowlim()))
            mflag = 1'h1;
        if (!on)
            mflag = 1'h0;
        chk(32'(window_monitor_flag), 32'(mflag));
        chk(32'(sequence_done), 32'(on && int'(ch) == last));
        chk(32'(converter_powered), 32'(on));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        logic [31:0] r;
        int          i;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (i = 8; i < 18; i++)
            mdl[i] = 8'h00;
        for (i = 8; i < 18; i++)
            rdchk(i);
        idle();
        outchk();
        $display("test reset_values done");
        converter_on <= 1'h1;
        for (i = 8; i < 18; i++)
            wr(i, (i == 10) ? 8'hcf : 8'hff);
        for (i = 8; i < 18; i++)
            rdchk(i);
        idle();
        outchk();
        $display("test all_ones done");
        apb(1'h1, 18, 8'hff);
        chk(32'(err), 32'h1);
        apb(1'h0, 18, 8'h00);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        idle();
        $display("test unmapped done");
        for (i = 0; i < 4; i++)
        begin
            resolution <= asw_res_t'(i);
            wr(8, 8'hff);
            wr(9, 8'hff);
            rdchk(8);
            rdchk(9);
            idle();
            outchk();
        end
        $display("test resolutions done");
        repeat (60)
        begin
            r = xs();
            i = 8 + int'(r[7:0] % 8'd10);
            resolution <= asw_res_t'(r[9:8]);
            r = xs();
            wr(i, (i == 10) ? (r[7:0] & 8'hcf) : r[7:0]);
            rdchk(i);
        end
        for (i = 8; i < 18; i++)
            rdchk(i);
        idle();
        outchk();
        $display("test random done");
        resolution <= ASW_RES_12;
        wr(8, 8'h01);
        wr(9, 8'h00);
        wr(10, 8'h00);
        wr(11, 8'h00);
        wr(12, 8'h00);
        wr(13, 8'h05);
        idle();
        conv(5'h00, 12'h400);
        conv(5'h02, 12'h900);
        conv(5'h01, 12'h400);
        window_flag_clear <= 1'h1;
        @(posedge pclk);
        window_flag_clear <= 1'h0;
        #1;
        chk(32'(window_monitor_flag), 32'h0);
        mflag = 1'h0;
        conv(5'h01, 12'h050);
        converter_on <= 1'h0;
        conv(5'h02, 12'h900);
        $display("test window_and_scan done");
        finish_test();
    end
endmodule // asw_regs_tb_top
`default_nettype wire
